// File: hdl/mcuexe_alu.v
`timescale 1ns/100ps
module mcuexe_alu (
  input  wire [2:0] op,      // Decoded operation
  input  wire [7:0] mem_rd,  // Addressed memory byte
  output reg  [7:0] result,  // Eight-bit result
  output wire       zero     // Result is zero
);
`include "mcuexe_consts.vh"
  always @* begin
    case (op)
      `MCUEXE_OP_DEC_W: result = mem_rd - 8'h01;
      `MCUEXE_OP_INC_M,
      `MCUEXE_OP_INC_W: result = mem_rd + 8'h01;
      default:          result = mem_rd;
    endcase
  end
  assign zero = (result == 8'h00);
endmodule // mcuexe_alu

// File: hdl/mcuexe_consts.vh
// What this block does
// - Decrement to work register, memory unchanged
// - Power-down stops execution, keeps all contents
// - Power-down clears watchdog counter and prescaler
// - Power-down sets power flag, clears timeout
// - Increment memory byte in place, zero flag
// - Increment to work register, memory unchanged
// - Branch loads program counter, no flags
// - Branch takes two cycles, dummy slot
// - Copy memory byte to work register
`ifndef MCUEXE_CONSTS_VH
`define MCUEXE_CONSTS_VH
// ----------------------------------------
// Operation codes on the decoded-op port
// ----------------------------------------
`define MCUEXE_OP_NOP     3'h0
`define MCUEXE_OP_DEC_W   3'h1
`define MCUEXE_OP_HALT    3'h2
`define MCUEXE_OP_INC_M   3'h3
`define MCUEXE_OP_INC_W   3'h4
`define MCUEXE_OP_BRANCH  3'h5
`define MCUEXE_OP_COPY_M  3'h6
`define MCUEXE_OP_COPY_K  3'h7
// ----------------------------------------
// Reset values
// ----------------------------------------
`define MCUEXE_PC_RST     11'h000
`define MCUEXE_W_RST      8'h00
`endif

// File: hdl/mcuexe_top.v
`timescale 1ns/100ps
module mcuexe_top #(
  parameter PC_W = 11                  // Program counter width
) (
  input  wire            clock,        // 50 MHz system clock
  input  wire            reset,        // Asynchronous, active high
  input  wire            instr_valid,  // Decoded instruction offered
  input  wire [2:0]      instr_op,     // Operation code
  input  wire [7:0]      instr_imm,    // Immediate constant
  input  wire [PC_W-1:0] instr_addr,   // Branch target
  input  wire [7:0]      mem_rd,       // Addressed memory byte
  input  wire            wake,         // Leave power-down
  output reg             instr_ack_q,  // Instruction retired
  output reg  [7:0]      work_reg_q,   // Working register
  output reg             zero_flag_q,  // Zero flag
  output reg  [PC_W-1:0] pc_q,         // Program counter
  output reg             mem_we_q,     // Memory write strobe
  output reg  [7:0]      mem_wd_q,     // Memory write data
  output reg             power_down_flag_q,       // Power-down flag
  output reg             watchdog_timeout_flag_q, // Watchdog timeout flag
  output reg             watchdog_timer_clr_q,    // Clear watchdog and prescaler
  output reg             clock_run_q,  // System clock enabled
  output reg             busy_q        // Dummy branch slot in progress
);
`include "mcuexe_consts.vh"
  // ----------------------------------------
  // Arithmetic
  // ----------------------------------------
  wire [7:0] alu_res;
  wire       alu_zero;
  mcuexe_alu u_alu (
    .op     (instr_op),
    .mem_rd (mem_rd),
    .result (alu_res),
    .zero   (alu_zero)
  );
  // ----------------------------------------
  // Wake synchroniser
  // ----------------------------------------
  // Wake comes from a pin, so two flops stand before any logic
  reg        wake_meta_q;
  reg        wake_sync_q;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end else begin
      wake_meta_q <= wake;
      wake_sync_q <= wake_meta_q;
    end
  end
  // ----------------------------------------
  // Acceptance
  // ----------------------------------------
  // Instructions are refused while halted or in the dummy slot
  wire       running;
  wire       take;
  assign running = clock_run_q & ~busy_q;
  assign take    = instr_valid & running;
  // ----------------------------------------
  // Sequencing: program counter, slot, run, retire
  // ----------------------------------------
  reg [PC_W-1:0] pc_d;
  reg            busy_d;
  reg            clock_run_d;
  reg            instr_ack_d;
  always @* begin
    pc_d        = pc_q;
    busy_d      = 1'b0;
    clock_run_d = clock_run_q;
    instr_ack_d = 1'b0;
    if (!clock_run_q) begin
      // Registers hold; only a synchronised wake restarts
      if (wake_sync_q) begin
        clock_run_d = 1'b1;
      end
    end else if (busy_q) begin
      // Branch retires at the end of its dummy slot
      instr_ack_d = 1'b1;
    end else if (take) begin
      case (instr_op)
        `MCUEXE_OP_BRANCH: begin
          pc_d   = instr_addr;
          busy_d = 1'b1;
        end
        `MCUEXE_OP_HALT: begin
          clock_run_d = 1'b0;
          pc_d        = pc_q + 1'b1;
          instr_ack_d = 1'b1;
        end
        default: begin
          pc_d        = pc_q + 1'b1;
          instr_ack_d = 1'b1;
        end
      endcase
    end
  end
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pc_q        <= `MCUEXE_PC_RST;
      busy_q      <= 1'b0;
      clock_run_q <= 1'b1;
      instr_ack_q <= 1'b0;
    end else begin
      pc_q        <= pc_d;
      busy_q      <= busy_d;
      clock_run_q <= clock_run_d;
      instr_ack_q <= instr_ack_d;
    end
  end
  // ----------------------------------------
  // Working register and zero flag
  // ----------------------------------------
  reg [7:0] work_reg_d;
  reg       zero_flag_d;
  always @* begin
    work_reg_d  = work_reg_q;
    zero_flag_d = zero_flag_q;
    if (take) begin
      case (instr_op)
        `MCUEXE_OP_DEC_W,
        `MCUEXE_OP_INC_W: begin
          work_reg_d  = alu_res;
          zero_flag_d = alu_zero;
        end
        `MCUEXE_OP_INC_M: begin
          // Result goes to memory; only the flag lands here
          zero_flag_d = alu_zero;
        end
        `MCUEXE_OP_COPY_M: begin
          work_reg_d = mem_rd;
        end
        `MCUEXE_OP_COPY_K: begin
          work_reg_d = instr_imm;
        end
        default: begin
          // Branch, halt and no-op leave both untouched
          work_reg_d  = work_reg_q;
          zero_flag_d = zero_flag_q;
        end
      endcase
    end
  end
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      work_reg_q  <= `MCUEXE_W_RST;
      zero_flag_q <= 1'b0;
    end else begin
      work_reg_q  <= work_reg_d;
      zero_flag_q <= zero_flag_d;
    end
  end
  // ----------------------------------------
  // Memory write-back
  // ----------------------------------------
  // Write data is held after the strobe so the memory sees it settled
  reg       mem_we_d;
  reg [7:0] mem_wd_d;
  always @* begin
    mem_we_d = 1'b0;
    mem_wd_d = mem_wd_q;
    if (take && (instr_op == `MCUEXE_OP_INC_M)) begin
      mem_we_d = 1'b1;
      mem_wd_d = alu_res;
    end
  end
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      mem_we_q <= 1'b0;
      mem_wd_q <= 8'h00;
    end else begin
      mem_we_q <= mem_we_d;
      mem_wd_q <= mem_wd_d;
    end
  end
  // ----------------------------------------
  // Power-down status and watchdog clear
  // ----------------------------------------
  // Nothing in the design sets the timeout flag; this block only clears it on power-down
  reg       power_down_flag_d;
  reg       watchdog_timeout_flag_d;
  reg       watchdog_timer_clr_d;
  always @* begin
    power_down_flag_d       = power_down_flag_q;
    watchdog_timeout_flag_d = watchdog_timeout_flag_q;
    watchdog_timer_clr_d    = 1'b0;
    if (take && (instr_op == `MCUEXE_OP_HALT)) begin
      watchdog_timer_clr_d    = 1'b1;
      power_down_flag_d       = 1'b1;
      watchdog_timeout_flag_d = 1'b0;
    end
  end
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      power_down_flag_q       <= 1'b0;
      watchdog_timeout_flag_q <= 1'b0;
      watchdog_timer_clr_q    <= 1'b0;
    end else begin
      power_down_flag_q       <= power_down_flag_d;
      watchdog_timeout_flag_q <= watchdog_timeout_flag_d;
      watchdog_timer_clr_q    <= watchdog_timer_clr_d;
    end
  end
endmodule // mcuexe_top

// File: tb/mcuexe_checker.sv
`timescale 1ns/100ps
module mcuexe_checker (
  input wire clock, reset, instr_valid, instr_ack_q, zero_flag_q, mem_we_q, busy_q, // Control
  input wire power_down_flag_q, watchdog_timeout_flag_q, watchdog_timer_clr_q, clock_run_q, // Power
  input wire [2:0] instr_op, // Op
  input wire [7:0] mem_rd, work_reg_q, mem_wd_q, instr_imm, // Data
  input wire [10:0] instr_addr, pc_q // Address
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire [2:0] t = instr_valid & clock_run_q & !busy_q ? instr_op : 3'h0;
  sequence s_slot; busy_q && !instr_ack_q; endsequence
  sequence s_done; instr_ack_q && !busy_q; endsequence
  property p_dec; t==3'h1 |=> work_reg_q==$past(mem_rd)-8'h01 && zero_flag_q==(work_reg_q==8'h00); endproperty
  a_dec: assert property (p_dec) else $error("dec");
  property p_halt; t==3'h2 |=> !clock_run_q && $stable(work_reg_q); endproperty
  a_halt: assert property (p_halt) else $error("halt");
  property p_clr; t==3'h2 |=> watchdog_timer_clr_q ##1 !watchdog_timer_clr_q; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_flag; t==3'h2 |=> power_down_flag_q && !watchdog_timeout_flag_q; endproperty
  a_flag: assert property (p_flag) else $error("flag");
  property p_incm; t==3'h3 |=> mem_we_q && mem_wd_q==$past(mem_rd)+8'h01; endproperty
  a_incm: assert property (p_incm) else $error("incm");
  property p_incw; t==3'h4 |=> !mem_we_q && work_reg_q==$past(mem_rd)+8'h01; endproperty
  a_incw: assert property (p_incw) else $error("incw");
  property p_br; t==3'h5 |=> s_slot ##1 s_done; endproperty
  a_br: assert property (p_br) else $error("br");
  property p_pc; t==3'h5 |=> pc_q==$past(instr_addr) && $stable(zero_flag_q); endproperty
  a_pc: assert property (p_pc) else $error("pc");
  property p_copym; t==3'h6 |=> work_reg_q==$past(mem_rd) && $stable(zero_flag_q); endproperty
  a_copym: assert property (p_copym) else $error("copym");
  property p_copyk; t==3'h7 |=> work_reg_q==$past(instr_imm) && $stable(zero_flag_q); endproperty
  a_copyk: assert property (p_copyk) else $error("copyk");
endmodule // mcuexe_checker
bind mcuexe_top mcuexe_checker mcuexe_checker_i (.*);

// File: tb/mcuexe_mem.sv
`timescale 1ns/100ps
// One byte stands for the addressed location; the bench preloads rd
module mcuexe_mem (
  input  wire       clock, // Clock
  input  wire       we,    // Write strobe
  input  wire [7:0] wd,    // Write data
  output reg  [7:0] rd = 8'h00 // Addressed byte
);
  always @(posedge clock) if (we) rd <= wd;
endmodule // mcuexe_mem

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  reg clock = 1'h0, reset = 1'h1, instr_valid = 1'h0, wake = 1'h0;
  reg [2:0] instr_op = 3'h0;
  reg [7:0] instr_imm = 8'h00;
  reg [10:0] instr_addr = 11'h000;
  wire instr_ack_q, zero_flag_q, mem_we_q, power_down_flag_q, watchdog_timeout_flag_q, watchdog_timer_clr_q;
  wire clock_run_q, busy_q;
  wire [7:0] mem_rd, work_reg_q, mem_wd_q;
  wire [10:0] pc_q;
  int n_errors = 0, compares = 0;
  always #10 clock = ~clock;
  mcuexe_top mcuexe_top_i (.clock(clock), .reset(reset), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_imm(instr_imm), .instr_addr(instr_addr), .mem_rd(mem_rd), .wake(wake), .instr_ack_q(instr_ack_q),
    .work_reg_q(work_reg_q), .zero_flag_q(zero_flag_q), .pc_q(pc_q), .mem_we_q(mem_we_q), .mem_wd_q(mem_wd_q),
    .power_down_flag_q(power_down_flag_q), .watchdog_timeout_flag_q(watchdog_timeout_flag_q),
    .watchdog_timer_clr_q(watchdog_timer_clr_q), .clock_run_q(clock_run_q), .busy_q(busy_q));
  mcuexe_mem mcuexe_mem_i (.clock(clock), .we(mem_we_q), .wd(mem_wd_q), .rd(mem_rd));
  task chk(input [10:0] s, e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task print_verdict;
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Idle cycle first so valid is never lowered and raised in one step
  task op(input [2:0] o, input [7:0] v, k);
    @(negedge clock) mcuexe_mem_i.rd = v;
    {instr_valid, instr_op, instr_imm, instr_addr} = {1'h1, o, k, 3'h0, k};
    @(negedge clock) instr_valid = 1'h0;
  endtask
  task t_data;
    op(3'h4, 8'hff, 8'h00); chk(work_reg_q, 8'h00); chk(zero_flag_q, 1'h1);
    op(3'h6, 8'h5a, 8'h00); chk(work_reg_q, 8'h5a); chk(zero_flag_q, 1'h1);
    op(3'h1, 8'h00, 8'h00); chk(work_reg_q, 8'hff); chk(zero_flag_q, 1'h0);
    op(3'h3, 8'h7f, 8'h00); chk(mem_wd_q, 8'h80); chk(work_reg_q, 8'hff);
    @(negedge clock) chk(mem_rd, 8'h80);
  endtask
  task t_ctl;
    op(3'h7, 8'h00, 8'h3c); chk(work_reg_q, 8'h3c);
    op(3'h5, 8'h00, 8'h44); chk(pc_q, 11'h044); chk(instr_ack_q, 1'h0);
    @(negedge clock) chk(instr_ack_q, 1'h1);
    op(3'h2, 8'h00, 8'h00); chk(power_down_flag_q, 1'h1); chk(watchdog_timeout_flag_q, 1'h0);
    chk(watchdog_timer_clr_q, 1'h1);
    op(3'h4, 8'h00, 8'h00); chk(work_reg_q, 8'h3c); chk(instr_ack_q, 1'h0);
    @(negedge clock) wake = 1'h1;
    repeat (3) @(negedge clock);
    chk(clock_run_q, 1'h1);
    wake = 1'h0;
    op(3'h4, 8'h00, 8'h00); chk(work_reg_q, 8'h01); chk(instr_ack_q, 1'h1);
  endtask
  initial begin
    repeat (6) @(negedge clock);
    reset = 1'h0;
    t_data;
    t_ctl;
    print_verdict;
  end
  initial begin
    #100000;
    n_errors++;
    print_verdict;
  end
endmodule // testbench
